// >>> hdl/ssl_port.sv
// Function
// - clock enable high freezes every stage but pin driver enable and sleep delay line
// - synchronous inputs taken on rising edge
// - all three selects needed; one deselects
// - selects one and three low, two high
// - read starts on enabled selected load read
// - pipelined read drives one edge later
// - write taken when selected, enabled, write low
// - each lane enable gates its lane
// - no lane enabled means aborted write
// - pipelined write data at third edge
// - flow-through read drives after address edge
// - flow-through write data at second edge
// - step high advances; same in both modes
// - low address bits preset burst counter
// - enables and lane strobes active low
// - nine bits per lane, own strobe each
// - latency select high means pipelined
// - step uses counter address for access
// - counter wraps after four addresses
`timescale 1ns/10ps
module ssl_port (
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic [ssl_pkg::ADDR_W-1:0] addr,
  input  wire logic                       sel_first_n,
  input  wire logic                       sel_second,
  input  wire logic                       sel_third_n,
  input  wire logic                       wr_n,
  input  wire logic                       lane0_wr_n,
  input  wire logic                       lane1_wr_n,
  input  wire logic                       lane2_wr_n,
  input  wire logic                       lane3_wr_n,
  input  wire logic                       load_or_step,
  input  wire logic                       clk_en_n,
  input  wire logic                       out_en_n,
  input  wire logic                       sleep_req,
  input  wire logic                       burst_order_sel,
  input  wire logic                       latency_mode_sel,
  input  wire logic [ssl_pkg::DATA_W-1:0] data_in,
  output logic [ssl_pkg::DATA_W-1:0]      data_out,
  output logic                            data_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ssl_pkg::ssl_state_t          st_q;         // burst kind
  logic [1:0]                   cnt_q;        // burst counter
  logic [1:0]                   start_q;      // preset low bits
  logic [ssl_pkg::ADDR_W-1:0]   base_q;       // loaded address
  logic                         s1_rd_q;      // read one edge back
  logic                         s1_wr_q;      // write one edge back
  logic                         s2_wr_q;      // write two edges back
  logic [ssl_pkg::ADDR_W-1:0]   s1_addr_q;    // read address one back
  logic [ssl_pkg::DATA_W-1:0]   dout_q;       // output register
  logic                         drive_q;      // read data held
  logic                         oe_q;         // pin driver enable
  logic [ssl_pkg::SLEEP_DLY-1:0] sleep_q;     // sleep delay line

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic                         asleep;       // sleep in force
  logic                         wq_ready;     // write queue has room
  logic                         en;           // edge takes effect
  logic                         pipe;         // pipelined mode
  logic                         selected;     // all selects active
  logic                         load;         // fresh address cycle
  logic                         rd_start;     // read, begin burst
  logic                         wr_start;     // write, begin burst
  logic                         step;         // continue burst
  logic                         do_rd;        // read this edge
  logic                         do_wr;        // write this edge
  logic [ssl_pkg::LANES-1:0]    lane_we;      // lanes, active high
  logic [ssl_pkg::ADDR_W-1:0]   step_addr;    // counter address
  logic [ssl_pkg::ADDR_W-1:0]   cur_addr;     // address of this edge
  logic [1:0]                   cnt_next;     // counter after step

  assign asleep   = sleep_q[ssl_pkg::SLEEP_DLY-1];
  assign en       = ~clk_en_n & ~asleep & wq_ready;
  assign pipe     = (latency_mode_sel == ssl_pkg::MODE_PIPE);
  assign selected = ~sel_first_n & sel_second & ~sel_third_n;
  assign load     = ~load_or_step;
  assign rd_start = load & selected & wr_n;
  assign wr_start = load & selected & ~wr_n;
  assign step     = load_or_step & (st_q != ssl_pkg::SSL_DESEL);
  assign do_rd    = rd_start | (step & (st_q == ssl_pkg::SSL_READ));
  assign do_wr    = wr_start | (step & (st_q == ssl_pkg::SSL_WRITE));
  assign lane_we  = ~{lane3_wr_n, lane2_wr_n, lane1_wr_n, lane0_wr_n};
  assign cnt_next = 2'(cnt_q + ssl_pkg::BURST_ONE);
  assign step_addr = {base_q[ssl_pkg::ADDR_W-1:ssl_pkg::BURST_W],
                      ssl_pkg::burst_low(start_q, cnt_next,
                                         burst_order_sel)};
  assign cur_addr = load ? addr : step_addr;

  // ---------------------------------------------------------------
  // late write queue and core array
  // ---------------------------------------------------------------
  ssl_pkg::ssl_wcmd_t           wq_in;        // command to queue
  ssl_pkg::ssl_wcmd_t           wq_head;      // oldest command
  logic                         wq_valid;     // queue not empty
  logic                         due;          // write data on pins now
  logic                         wq_pop;       // consume head
  logic [ssl_pkg::LANES-1:0]    mem_we;       // lane strobes to core
  logic                         rd_now;       // output register loads
  logic [ssl_pkg::ADDR_W-1:0]   raddr;        // core read address
  logic [ssl_pkg::DATA_W-1:0]   rdata;        // core read data
  logic                         drive_next;   // drive after this edge

  assign wq_in.addr  = cur_addr;
  assign wq_in.lanes = lane_we;
  assign due    = pipe ? s2_wr_q : s1_wr_q;
  assign wq_pop = en & due;
  assign mem_we = (wq_pop & wq_valid) ? wq_head.lanes : '0;
  assign rd_now = pipe ? s1_rd_q : do_rd;
  assign raddr  = pipe ? s1_addr_q : cur_addr;
  assign drive_next = en ? rd_now : drive_q;

  // commands wait here until their data arrives
  ssl_fifo #(
    .WIDTH ($bits(ssl_pkg::ssl_wcmd_t)),
    .DEPTH (ssl_pkg::WQ_DEPTH)
  ) u_wq (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (~clk_en_n & ~asleep & do_wr),
    .in_ready  (wq_ready),
    .in_data   (wq_in),
    .out_valid (wq_valid),
    .out_ready (wq_pop),
    .out_data  (wq_head)
  );

  // nine-bit lanes, one strobe each
  ssl_mem #(
    .ADDR_W (ssl_pkg::ADDR_W),
    .LANES  (ssl_pkg::LANES),
    .LANE_W (ssl_pkg::LANE_W)
  ) u_mem (
    .mclk     (mclk),
    .we_lanes (mem_we),
    .waddr    (wq_head.addr),
    .wdata    (data_in),
    .raddr    (raddr),
    .rdata    (rdata)
  );

  // ---------------------------------------------------------------
  // burst control
  // ---------------------------------------------------------------
  // burst kind follows each load, held over continues
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ssl_pkg::SSL_DESEL;
    end else if (en && load) begin
      st_q <= !selected ? ssl_pkg::SSL_DESEL :
              wr_n      ? ssl_pkg::SSL_READ  : ssl_pkg::SSL_WRITE;
    end
  end

  // counter preset on load, stepped on continue
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= ssl_pkg::BURST_ZERO;
      start_q <= ssl_pkg::BURST_ZERO;
      base_q  <= '0;
    end else if (en && load) begin
      cnt_q   <= ssl_pkg::BURST_ZERO;
      start_q <= addr[ssl_pkg::BURST_W-1:0];
      base_q  <= addr;
    end else if (en && step) begin
      cnt_q   <= cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // data pipeline
  // ---------------------------------------------------------------
  // operation stages, frozen while stalled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_rd_q   <= 1'b0;
      s1_wr_q   <= 1'b0;
      s2_wr_q   <= 1'b0;
      s1_addr_q <= '0;
    end else if (en) begin
      s1_rd_q   <= do_rd;
      s1_wr_q   <= do_wr;
      s2_wr_q   <= s1_wr_q;
      s1_addr_q <= cur_addr;
    end
  end

  // output register, holds through a stall
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dout_q  <= '0;
      drive_q <= 1'b0;
    end else if (en) begin
      drive_q <= rd_now;
      if (rd_now) dout_q <= rdata;
    end
  end

  // driver enable, output enable and sleep act every edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oe_q    <= 1'b0;
      sleep_q <= '0;
    end else begin
      oe_q    <= drive_next & ~out_en_n & ~sleep_req;
      sleep_q <= {sleep_q[ssl_pkg::SLEEP_DLY-2:0], sleep_req};
    end
  end

  assign data_out = dout_q;
  assign data_oe  = oe_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  stall_hold_a: assert property (!en |=> $stable(data_out))
    else $error("output register moved during stall");
  desel_idle_a: assert property (
    en && load && !selected |=> !s1_rd_q && !s1_wr_q)
    else $error("deselected load started an access");
  flow_read_a: assert property (
    en && do_rd && !pipe && !out_en_n && !sleep_req
    |=> data_oe && data_out == $past(rdata))
    else $error("flow-through read not driven after one edge");
  pipe_read_a: assert property (
    (en && rd_start && pipe) ##1
    (en && pipe && !out_en_n && !sleep_req) |=> data_oe)
    else $error("pipelined read not driven at second edge");
  pipe_write_a: assert property (
    (en && wr_start && pipe && lane_we != '0) ##1 (en && pipe)
    ##1 (en && pipe) |-> mem_we != '0)
    else $error("pipelined write data not taken at third edge");
  flow_write_a: assert property (
    (en && wr_start && !pipe && lane_we != '0) ##1 (en && !pipe)
    |-> mem_we != '0)
    else $error("flow-through write data not taken at second edge");
  write_abort_a: assert property (
    (en && wr_start && !pipe && lane_we == '0) ##1 (en && !pipe)
    |-> mem_we == '0)
    else $error("aborted write changed the array");
  burst_wrap_a: assert property (
    en && step && cnt_q == ssl_pkg::BURST_LAST
    |=> cnt_q == ssl_pkg::BURST_ZERO)
    else $error("burst counter did not wrap after four");
  burst_preset_a: assert property (
    en && load |=> start_q == $past(addr[1:0]) && cnt_q == 2'h0)
    else $error("burst counter not preset from low address");
  write_quiet_a: assert property (
    en && do_wr && !pipe |=> !data_oe)
    else $error("pins driven during flow-through write");

  // pipelined write keeps the pins quiet at its data edge
  pipe_quiet_a: assert property (
    (en && do_wr && pipe) ##1 en |=> !data_oe)
    else $error("pins driven during pipelined write");

  // output enable and sleep release the pins at the next edge
  oe_gate_a: assert property (
    (out_en_n || sleep_req) |=> !data_oe)
    else $error("pins driven while output enable or sleep off");

  // ignored edges leave every stage and the counter alone
  stall_freeze_a: assert property (
    !en |=> $stable(st_q) && $stable(cnt_q) && $stable(s1_rd_q)
            && $stable(s1_wr_q) && $stable(s2_wr_q))
    else $error("state moved on an ignored edge");

  // counter steps by one on every continue
  burst_step_a: assert property (
    en && step |=> cnt_q == 2'($past(cnt_q) + 2'h1))
    else $error("burst counter did not step by one");

  // continue address: loaded upper bits, stepped low bits
  step_lin_a: assert property (
    en && step && burst_order_sel == ssl_pkg::ORDER_LIN
    |-> cur_addr[1:0] == 2'(start_q + cnt_q + 2'h1)
        && cur_addr[ssl_pkg::ADDR_W-1:2] == base_q[ssl_pkg::ADDR_W-1:2])
    else $error("linear burst step address wrong");
  step_ilv_a: assert property (
    en && step && burst_order_sel != ssl_pkg::ORDER_LIN
    |-> cur_addr[1:0] == (start_q ^ 2'(cnt_q + 2'h1)))
    else $error("interleaved burst step address wrong");

  // the late write queue never holds back a command
  queue_room_a: assert property (wq_ready)
    else $error("late write queue ran full");

  pipe_read_c:  cover property (en && rd_start && pipe ##1 en ##1 data_oe);
  flow_write_c: cover property (en && wr_start && !pipe ##1 mem_we != '0);
  burst_wrap_c: cover property (en && step && cnt_q == ssl_pkg::BURST_LAST);
  stall_c:      cover property (drive_q && clk_en_n ##1 data_oe);
  oe_gate_c:    cover property (drive_q && out_en_n ##1 !data_oe);

endmodule // ssl_port

// >>> hdl/ssl_pkg.sv
package ssl_pkg;

  // ---------------------------------------------------------------
  // sizes of the array and the data bus
  // ---------------------------------------------------------------
  localparam int ADDR_W   = 20;              // word address width
  localparam int LANES    = 4;               // byte lanes per word
  localparam int LANE_W   = 9;               // bits per byte lane
  localparam int DATA_W   = LANES * LANE_W;  // data bus width
  localparam int WQ_DEPTH = 8;               // pending write queue depth

  // ---------------------------------------------------------------
  // burst counter and mode pins
  // ---------------------------------------------------------------
  localparam int         BURST_W    = 2;     // burst counter width
  localparam logic [1:0] BURST_LAST = 2'h3;  // last count before wrap
  localparam logic [1:0] BURST_ONE  = 2'h1;  // counter step
  localparam logic [1:0] BURST_ZERO = 2'h0;  // counter preset
  localparam logic       MODE_PIPE  = 1'b1;  // latency select: pipelined
  localparam logic       ORDER_LIN  = 1'b0;  // burst order: linear
  localparam int         SLEEP_DLY  = 2;     // cycles until sleep takes hold

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  // burst kind remembered for continue cycles
  typedef enum logic [1:0] {
    SSL_DESEL = 2'b00,
    SSL_READ  = 2'b01,
    SSL_WRITE = 2'b11
  } ssl_state_t;

  // write command waiting for its late data
  typedef struct packed {
    logic [ADDR_W-1:0] addr;   // word address
    logic [LANES-1:0]  lanes;  // lane write enables, active high
  } ssl_wcmd_t;

  // low address bits of a burst step
  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] cnt,
                                           input logic       order);
    burst_low = (order == ORDER_LIN) ? 2'(start + cnt) : (start ^ cnt);
  endfunction

endpackage

// >>> hdl/ssl_fifo.sv
`timescale 1ns/10ps
module ssl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];     // word storage
  logic [PW-1:0]    wp_q;              // write index
  logic [PW-1:0]    rp_q;              // read index
  logic [PW:0]      cnt_q;             // words held
  logic             push;              // accepted write
  logic             pop;               // accepted read

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : PW'(wp_q + 1'b1);
      if (pop)  rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : PW'(rp_q + 1'b1);
      cnt_q <= (PW+1)'(cnt_q + push - pop);
    end
  end

  // data store, no reset needed
  always_ff @(posedge mclk) begin
    if (push) mem_q[wp_q] <= in_data;
  end

endmodule // ssl_fifo

// >>> hdl/ssl_mem.sv
`timescale 1ns/10ps
module ssl_mem #(
  parameter int ADDR_W = 20,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  input  wire logic                    mclk,
  input  wire logic [LANES-1:0]        we_lanes,
  input  wire logic [ADDR_W-1:0]       waddr,
  input  wire logic [LANES*LANE_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0]       raddr,
  output logic [LANES*LANE_W-1:0]      rdata
);

  // ---------------------------------------------------------------
  // core array, one flop array per lane
  // ---------------------------------------------------------------
  // each lane owns its storage so no two processes share a variable
  genvar g;
  for (g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_q [2**ADDR_W];  // this lane of every word

    assign rdata[g*LANE_W +: LANE_W] = lane_q[raddr];

    // one write port per lane
    always_ff @(posedge mclk) begin
      if (we_lanes[g]) lane_q[waddr] <= wdata[g*LANE_W +: LANE_W];
    end
  end

endmodule // ssl_mem

// >>> bench/ssl_ctrl_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// controller model: drives the port's bus inputs, late write data
// ---------------------------------------------------------------
module ssl_ctrl_model (
  input  wire logic                       mclk,
  output logic [ssl_pkg::ADDR_W-1:0]      addr,
  output logic [2:0]                      sel,
  output logic                            wr_n,
  output logic [3:0]                      lanes_n,
  output logic                            load_or_step,
  output logic                            clk_en_n,
  output logic [ssl_pkg::DATA_W-1:0]      data_in
);
  logic [ssl_pkg::DATA_W-1:0] wq [0:3];  // late data, by enabled edge
  logic                       wv [0:3];  // slot holds data

  // idle bus at time zero: deselected, clock enabled
  initial begin
    sel          = 3'h6;
    wr_n         = 1'b1;
    lanes_n      = 4'hf;
    load_or_step = 1'b0;
    clk_en_n     = 1'b0;
    addr         = '0;
    data_in      = '0;
    wv           = '{4{1'b0}};
  end

  // one command for the coming edge; called just after an edge
  task automatic issue(input logic [2:0] s, input logic ce_n,
                       input logic w_n, input logic step,
                       input logic [ssl_pkg::ADDR_W-1:0] a,
                       input logic [3:0] ln, input int wlat,
                       input logic [ssl_pkg::DATA_W-1:0] d);
    // late data queued wlat enabled edges ahead
    if (wlat > 0 && !ce_n) begin
      wq[wlat] = d;
      wv[wlat] = 1'b1;
    end
    sel          = s;
    clk_en_n     = ce_n;
    wr_n         = w_n;
    load_or_step = step;
    addr         = a;
    lanes_n      = ln;
    // unowned data lines keep toggling so stale data cannot pass
    data_in      = wv[0] ? wq[0] : ~data_in;
    @(posedge mclk);
    #1;
    // only enabled edges move the data slots
    if (!ce_n) begin
      for (int k = 0; k < 3; k++) begin
        wq[k] = wq[k+1];
        wv[k] = wv[k+1];
      end
      wv[3] = 1'b0;
    end
  endtask
endmodule // ssl_ctrl_model

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ---------------------------------------------------------------
  // signals and reference state
  // ---------------------------------------------------------------
  typedef logic [ssl_pkg::DATA_W-1:0] ssl_word_t;
  logic                       mclk     = 1'b0;  // 100 MHz clock
  logic                       nrst     = 1'b0;  // reset, active low
  logic                       order    = 1'b0;  // burst order pin
  logic                       mode_sel = 1'b1;  // 1 pipelined
  logic [ssl_pkg::ADDR_W-1:0] addr;
  logic [2:0]                 sel;
  logic                       wr_n, step, ce_n, data_oe;
  logic [3:0]                 ln;
  ssl_word_t                  data_in, data_out;
  ssl_word_t                  mem [int];         // reference array
  logic                       eo = 1'b0;         // read due
  ssl_word_t                  ed;                // read value due
  logic                       oen = 1'b0;        // output enable pin
  logic                       slp = 1'b0;        // sleep request pin
  int                         pa [0:3];          // write address due
  logic [3:0]                 pl [0:3];          // lanes, active high
  ssl_word_t                  pd [0:3];          // write data due
  logic                       pv [0:3] = '{4{1'b0}};
  logic                       cur_oe = 1'b0;
  ssl_word_t                  cur_d;
  int                         kind, base, cnt, pipe = 1;
  int                         err_count, comparisons;
  logic [31:0]                rnd = 32'h80ef;    // stimulus lfsr

  always #5 mclk = ~mclk;

  ssl_ctrl_model u_ssl_ctrl_model (.mclk(mclk), .addr(addr), .sel(sel),
    .wr_n(wr_n), .lanes_n(ln), .load_or_step(step), .clk_en_n(ce_n),
    .data_in(data_in));

  ssl_port u_ssl_port (.mclk(mclk), .nrst(nrst), .addr(addr),
    .sel_first_n(sel[2]), .sel_second(sel[1]), .sel_third_n(sel[0]),
    .wr_n(wr_n), .lane0_wr_n(ln[0]), .lane1_wr_n(ln[1]),
    .lane2_wr_n(ln[2]), .lane3_wr_n(ln[3]), .load_or_step(step),
    .clk_en_n(ce_n), .out_en_n(oen), .sleep_req(slp),
    .burst_order_sel(order), .latency_mode_sel(mode_sel),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one bus cycle: reference update, drive, then compare the pins
  task automatic cyc(input logic [2:0] s, input logic c_n,
                     input logic w_n, input logic st, input int a,
                     input logic [3:0] l, input ssl_word_t d);
    int        ea;
    int        wl;
    ssl_word_t w;
    logic      exp_oe;
    wl = 0;
    if (!c_n) begin
      if (!st) begin
        base = a;
        cnt  = 0;
        kind = (s !== 3'h2) ? 0 : (w_n ? 1 : 2);
      end else cnt = (cnt + 1) % 4;
      ea = order ? ((base & ~3) | ((base ^ cnt) & 3))
                 : ((base & ~3) | ((base + cnt) & 3));
      // flow-through read sees the array before this edge's write
      if (kind == 1 && pipe == 0) begin
        eo = 1'b1;
        ed = mem[ea];
      end
      if (kind == 2) begin
        wl     = pipe + 1;
        pa[wl] = ea;
        pl[wl] = ~l;
        pd[wl] = d;
        pv[wl] = 1'b1;
      end
    end
    u_ssl_ctrl_model.issue(s, c_n, w_n, st, a[19:0], l, wl, d);
    // stalled edges leave the whole reference untouched
    if (!c_n) begin
      cur_oe = eo;
      cur_d  = ed;
      eo     = 1'b0;
      if (pv[0]) begin
        w = mem[pa[0]];
        for (int k = 0; k < 4; k++)
          if (pl[0][k]) w[9*k+:9] = pd[0][9*k+:9];
        mem[pa[0]] = w;
      end
      for (int k = 0; k < 3; k++) begin
        pa[k] = pa[k+1];
        pl[k] = pl[k+1];
        pd[k] = pd[k+1];
        pv[k] = pv[k+1];
      end
      pv[3] = 1'b0;
      // pipelined read sees the array after this edge's write
      if (kind == 1 && pipe == 1) begin
        eo = 1'b1;
        ed = mem[ea];
      end
    end
    exp_oe = cur_oe & ~oen & ~slp;
    comparisons++;
    if (data_oe !== exp_oe ||
        (exp_oe && data_out !== cur_d)) begin
      err_count++;
      $display("[FAIL] data_oe/data_out expected %0b/%h seen %0b/%h",
               exp_oe, cur_d, data_oe, data_out);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(3'h6, 1'b0, 1'b1, 1'b0, 0, 4'hf, '0);
  endtask

  task automatic rd(input int a);
    cyc(3'h2, 1'b0, 1'b1, 1'b0, a, 4'hf, '0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    kind = 0;
    for (int m = 1; m >= 0; m--) begin
      idle(3);
      mode_sel = m[0];
      pipe     = m;
      idle(3);
      // fill both regions with full words, back to back
      for (int a = 0; a < 32; a++) begin
        rnd = lfsr(rnd);
        cyc(3'h2, 1'b0, 1'b0, 1'b0, (a / 16) * 256 + a % 16, 4'h0,
            {rnd[3:0], rnd});
      end
      idle(3);
      for (int a = 0; a < 16; a++) rd(a);
      // each select inactive on its own must deselect
      cyc(3'h6, 1'b0, 1'b1, 1'b0, 5, 4'hf, '0);
      cyc(3'h0, 1'b0, 1'b1, 1'b0, 5, 4'hf, '0);
      cyc(3'h3, 1'b0, 1'b1, 1'b0, 5, 4'hf, '0);
      // bursts in both orders, running past the wrap
      for (int o = 0; o < 2; o++) begin
        idle(2);
        order = o[0];
        idle(2);
        rd(5);
        repeat (4) cyc(3'h6, 1'b0, 1'b0, 1'b1, 0, 4'hf, '0);
      end
      // stalls before and while read data is shown
      rd(9);
      cyc(3'h2, 1'b1, 1'b0, 1'b0, 3, 4'h0, '0);
      idle(1);
      cyc(3'h2, 1'b1, 1'b1, 1'b0, 4, 4'hf, '0);
      idle(2);
      // sleep releases the pins one edge after the request
      rd(9);
      slp = 1'b1;
      idle(5);
      slp = 1'b0;
      idle(3);
      // read straight after a write: old data until it lands
      cyc(3'h2, 1'b0, 1'b0, 1'b0, 256, 4'h0, 36'h1234);
      repeat (3) rd(256);
      idle(2);
      // random mix: turnarounds, lane masks, aborts, stalls, bursts
      repeat (200) begin
        rnd = lfsr(rnd);
        oen = (rnd[21:20] == 2'h3);
        cyc(rnd[5:4] == 2'h0 ? rnd[8:6] : 3'h2, rnd[10:9] == 2'h0,
            rnd[11], rnd[13:12] == 2'h0,
            rnd[11] ? int'(rnd[15:12]) : 256 + int'(rnd[15:12]),
            rnd[19:16], {rnd[3:0], rnd});
      end
      oen = 1'b0;
      idle(3);
      for (int a = 256; a < 272; a++) rd(a);
      idle(3);
    end
    test_done();
  end

  // watchdog against a hang
  initial begin
    repeat (50000) @(posedge mclk);
    err_count++;
    test_done();
  end
endmodule // tb_top
